//--- rtl/srcs_top.sv
module srcs_top
  import srcs_pkg::*;
#(
  parameter int QC_EDGES = QC_EDGES_DEF,
  parameter int CQ_TIMEOUT_CYCLES = CQ_TIMEOUT_CYC,
  parameter int VUP_CYCLES = VUP_CYC_DEF
)(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic pwr_on_req,
  input wire logic lowv_req,
  input wire logic ext_reset_n,
  input wire logic osc_clk_in,
  input wire logic osc_select_strap,
  input wire logic wake_irq_n,
  input wire logic core_irq,
  input wire srcs_bus_req_t bus_req,
  output logic [DATA_W-1:0] bus_rdata,
  output logic internal_reset,
  output logic osc_enable,
  output logic osc_selected,
  output logic self_clock,
  output logic colpitts_sel,
  output logic clocks_released,
  output logic vector_fetch,
  output logic vector_is_irq,
  output logic irq
);
  typedef enum {ST_RESET, ST_QCHECK, ST_STARTUP, ST_RUN, ST_WAIT, ST_PSTOP, ST_STOP,
    ST_RECOVER} srcs_state_t;
  typedef enum {GO_STARTUP, GO_IRQ, GO_RUN} srcs_goal_t;

  localparam logic [SU_W-1:0] SU_LAST = SU_W'(STARTUP_OSC - 1);
  localparam logic [1:0] EXT_LAST = 2'(RST_MIN_OSC - 1);
  localparam logic [REC_W-1:0] REC_WAIT = REC_W'(WRS_MAX_CYC - 2);
  localparam logic [REC_W-1:0] REC_PSTOP = REC_W'(VUP_CYCLES + WRS_MAX_CYC - 2);

  srcs_state_t state;
  srcs_state_t next_state;
  srcs_goal_t goal;
  logic [PIN_W-1:0] pin_raw;
  logic [PIN_W-1:0] pin_s;
  logic pwr_on_s;
  logic lowv_s;
  logic wake_s;
  logic osc_d;
  logic osc_edge;
  logic osc_tick;
  logic hard_rst;
  logic cold;
  logic ext_rst_act;
  logic [1:0] ext_cnt;
  logic [SU_W-1:0] su_cnt;
  logic [REC_W-1:0] rec_cnt;
  logic qc_start;
  logic qc_pass;
  logic qc_timeout;
  logic mon_fail;
  logic strap_q;
  logic [STICKY_W-1:0] sticky;
  logic [STICKY_W-1:0] sticky_set;
  logic [STICKY_W-1:0] sticky_clr;
  logic [INT_W-1:0] int_stat;
  logic [INT_W-1:0] int_en;
  logic [INT_W-1:0] int_ev;
  logic [INT_W-1:0] int_clr;
  logic [FLAG_W-1:0] flags;
  logic mode_wr;
  logic leave_reset;
  logic fetch_now;

  // pins from outside the clock domain
  assign pin_raw[P_PWR_ON] = pwr_on_req;
  assign pin_raw[P_LOWV] = lowv_req;
  assign pin_raw[P_EXT_N] = ext_reset_n;
  assign pin_raw[P_OSC] = osc_clk_in;
  assign pin_raw[P_STRAP] = osc_select_strap;
  assign pin_raw[P_WAKE_N] = wake_irq_n;

  genvar gi;
  generate
    for (gi = 0; gi < PIN_W; gi++)
    begin : g_pin
      srcs_sync #(
        .RST_VAL(PIN_RST[gi])
      ) u_sync (
        .sys_clk(sys_clk),
        .srst(srst),
        .async_in(pin_raw[gi]),
        .stable(pin_s[gi])
      );
    end
  endgenerate

  // decoded pin levels and oscillator tick
  assign pwr_on_s = pin_s[P_PWR_ON];
  assign lowv_s = pin_s[P_LOWV];
  assign wake_s = ~pin_s[P_WAKE_N];
  assign osc_edge = pin_s[P_OSC] & ~osc_d;
  assign osc_tick = osc_selected ? osc_edge : 1'b1;
  assign hard_rst = pwr_on_s | lowv_s;
  assign mode_wr = bus_req.wr && bus_req.addr == A_MODE;

  // oscillator edge history
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      osc_d <= 1'b0;
    end
    else
    begin
      osc_d <= pin_s[P_OSC];
    end
  end

  // external reset pulse qualifier in oscillator periods, or in bus cycles while the oscillator is not selected
  always_ff @(posedge sys_clk)
  begin
    if (srst || pin_s[P_EXT_N])
    begin
      ext_cnt <= '0;
      ext_rst_act <= 1'b0;
    end
    else if (osc_tick && !ext_rst_act)
    begin
      if (ext_cnt == EXT_LAST)
      begin
        ext_rst_act <= 1'b1;
      end
      else
      begin
        ext_cnt <= ext_cnt + 1'b1;
      end
    end
  end

  // sequencer next state
  always_comb
  begin
    next_state = state;
    if (hard_rst || ext_rst_act)
    begin
      next_state = ST_RESET;
    end
    else
    begin
      case (state)
        ST_RESET: next_state = cold ? ST_QCHECK : ST_STARTUP;
        ST_QCHECK:
        begin
          if (qc_pass || qc_timeout)
          begin
            next_state = (goal == GO_STARTUP) ? ST_STARTUP : ST_RUN;
          end
        end
        ST_STARTUP:
        begin
          if (osc_tick && su_cnt == SU_LAST)
          begin
            next_state = ST_RUN;
          end
        end
        ST_RUN:
        begin
          if (mode_wr && bus_req.wdata[MODE_W-1:0] == MODE_WAIT)
          begin
            next_state = ST_WAIT;
          end
          else if (mode_wr && bus_req.wdata[MODE_W-1:0] == MODE_PSTOP)
          begin
            next_state = ST_PSTOP;
          end
          else if (mode_wr && bus_req.wdata[MODE_W-1:0] == MODE_STOP)
          begin
            next_state = ST_STOP;
          end
          else if (mon_fail && osc_selected)
          begin
            next_state = ST_QCHECK;
          end
        end
        ST_WAIT, ST_PSTOP:
        begin
          if (core_irq || wake_s)
          begin
            next_state = ST_RECOVER;
          end
        end
        ST_STOP:
        begin
          if (wake_s)
          begin
            next_state = ST_QCHECK;
          end
        end
        ST_RECOVER:
        begin
          if (rec_cnt == '0)
          begin
            next_state = ST_RUN;
          end
        end
        default: next_state = ST_RESET;
      endcase
    end
  end

  assign leave_reset = state == ST_RESET && next_state != ST_RESET;
  assign qc_start = next_state == ST_QCHECK && state != ST_QCHECK;
  assign fetch_now = state != ST_RUN && next_state == ST_RUN && state != ST_QCHECK
    || state == ST_QCHECK && next_state == ST_RUN && goal == GO_IRQ;

  // state register
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      state <= ST_RESET;
    end
    else
    begin
      state <= next_state;
    end
  end

  // cold start marker: check needed unless the oscillator is selected when the external reset comes
  always_ff @(posedge sys_clk)
  begin
    if (srst || hard_rst)
    begin
      cold <= 1'b1;
    end
    else if (ext_rst_act)
    begin
      cold <= ~osc_selected;
    end
  end

  // where a finished quality check leads
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      goal <= GO_STARTUP;
    end
    else if (qc_start)
    begin
      case (state)
        ST_STOP: goal <= GO_IRQ;
        ST_RUN: goal <= GO_RUN;
        default: goal <= GO_STARTUP;
      endcase
    end
  end

  // startup period counter
  always_ff @(posedge sys_clk)
  begin
    if (srst || state != ST_STARTUP)
    begin
      su_cnt <= '0;
    end
    else if (osc_tick)
    begin
      su_cnt <= su_cnt + 1'b1;
    end
  end

  // wake recovery delay
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      rec_cnt <= '0;
    end
    else if (next_state == ST_RECOVER && state != ST_RECOVER)
    begin
      rec_cnt <= (state == ST_WAIT) ? REC_WAIT : REC_PSTOP;
    end
    else if (rec_cnt != '0)
    begin
      rec_cnt <= rec_cnt - 1'b1;
    end
  end

  srcs_osc_mon #(
    .QC_EDGES(QC_EDGES),
    .TIMEOUT_CYC(CQ_TIMEOUT_CYCLES),
    .GAP_CYC(CM_CYC)
  ) u_mon (
    .sys_clk(sys_clk),
    .srst(srst),
    .start(qc_start),
    .active(osc_selected && state != ST_STOP),
    .osc_edge(osc_edge),
    .qc_pass(qc_pass),
    .qc_timeout(qc_timeout),
    .mon_fail(mon_fail)
  );

  // clock source selection
  always_ff @(posedge sys_clk)
  begin
    if (srst || hard_rst)
    begin
      osc_selected <= 1'b0;
      self_clock <= 1'b0;
    end
    else if (state == ST_QCHECK && qc_pass)
    begin
      osc_selected <= 1'b1;
      self_clock <= 1'b0;
    end
    else if (state == ST_QCHECK && qc_timeout)
    begin
      osc_selected <= 1'b0;
      self_clock <= 1'b1;
    end
    else if (mon_fail && osc_selected)
    begin
      osc_selected <= 1'b0;
      self_clock <= 1'b1;
    end
    else if (next_state == ST_STOP)
    begin
      osc_selected <= 1'b0;
    end
  end

  // oscillator power, off in stop and while supply resets hold
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      osc_enable <= 1'b0;
    end
    else
    begin
      osc_enable <= next_state != ST_STOP && !hard_rst;
    end
  end

  // reset, clock gate and vector fetch outputs
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      internal_reset <= 1'b1;
      clocks_released <= 1'b0;
      vector_fetch <= 1'b0;
      vector_is_irq <= 1'b0;
    end
    else
    begin
      internal_reset <= next_state == ST_RESET || next_state == ST_STARTUP
        || next_state == ST_QCHECK && (state == ST_RESET
        || state == ST_QCHECK && goal == GO_STARTUP);
      clocks_released <= next_state == ST_RUN || state == ST_RUN && next_state == ST_QCHECK
        || state == ST_QCHECK && next_state == ST_QCHECK && goal == GO_RUN;
      vector_fetch <= fetch_now;
      if (fetch_now)
      begin
        vector_is_irq <= state != ST_STARTUP;
      end
    end
  end

  // strap caught while reset holds
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      strap_q <= 1'b1;
    end
    else if (state == ST_RESET)
    begin
      strap_q <= pin_s[P_STRAP];
    end
  end

  assign colpitts_sel = strap_q;

  // sticky reset-cause flags, set beats clear
  assign sticky_set[F_PWR_ON] = pwr_on_s;
  assign sticky_set[F_LOWV] = lowv_s;
  assign sticky_set[F_EXT] = ext_rst_act;
  assign sticky_set[F_MON] = mon_fail && osc_selected;
  assign sticky_clr = (bus_req.wr && bus_req.addr == A_FLAG_CLR)
    ? bus_req.wdata[STICKY_W-1:0] : '0;

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      sticky <= '0;
    end
    else
    begin
      sticky <= sticky_set | (sticky & ~sticky_clr);
    end
  end

  assign flags = {strap_q, osc_selected, self_clock, sticky};

  // interrupt events, status, enable
  assign int_ev[I_QC_DONE] = state == ST_QCHECK && qc_pass;
  assign int_ev[I_FALLBACK] = state == ST_QCHECK && qc_timeout;
  assign int_ev[I_MON] = mon_fail && osc_selected;
  assign int_ev[I_WAKE] = fetch_now && state != ST_STARTUP;
  assign int_clr = (bus_req.wr && bus_req.addr == A_INT_CLR) ? bus_req.wdata[INT_W-1:0] : '0;

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      int_stat <= '0;
      int_en <= '0;
      irq <= 1'b0;
    end
    else
    begin
      int_stat <= int_ev | (int_stat & ~int_clr);
      if (bus_req.wr && bus_req.addr == A_INT_EN)
      begin
        int_en <= bus_req.wdata[INT_W-1:0];
      end
      irq <= |(int_stat & int_en);
    end
  end

  // read port, data valid the cycle after the strobe only
  always_ff @(posedge sys_clk)
  begin
    if (srst || !bus_req.rd)
    begin
      bus_rdata <= '0;
    end
    else
    begin
      case (bus_req.addr)
        A_FLAGS: bus_rdata <= DATA_W'(flags);
        A_INT_STAT: bus_rdata <= DATA_W'(int_stat);
        A_INT_EN: bus_rdata <= DATA_W'(int_en);
        default: bus_rdata <= '0;
      endcase
    end
  end

  // checks
  AST_STARTUP_LEN: assert property (@(posedge sys_clk) disable iff (srst)
    $fell(internal_reset) |-> vector_fetch && !vector_is_irq && $past(su_cnt) == SU_LAST)
    else $error("startup length wrong");
  AST_EXT_MIN: assert property (@(posedge sys_clk) disable iff (srst)
    $rose(ext_rst_act) |-> $past(ext_cnt) == EXT_LAST && $past(osc_tick))
    else $error("external reset taken too early");
  AST_COLD_QC: assert property (@(posedge sys_clk) disable iff (srst)
    $past(state) == ST_RESET && state != ST_RESET && $past(cold) |-> state == ST_QCHECK
    && osc_enable)
    else $error("cold start skipped quality check");
  AST_TIMEOUT: assert property (@(posedge sys_clk) disable iff (srst)
    state == ST_QCHECK && qc_timeout && !hard_rst |=> self_clock && !osc_selected)
    else $error("no self clock after timeout");
  AST_QC_FIRST: assert property (@(posedge sys_clk) disable iff (srst)
    $rose(osc_selected) |-> $past(qc_pass))
    else $error("oscillator used without check");
  AST_WARM_EXT: assert property (@(posedge sys_clk) disable iff (srst)
    $past(state) == ST_RESET && state != ST_RESET && !$past(cold) |-> state == ST_STARTUP)
    else $error("warm reset ran a check");
  AST_PWR_FLAG: assert property (@(posedge sys_clk) disable iff (srst)
    $rose(sticky[F_PWR_ON]) |-> $past(pwr_on_s))
    else $error("power-on flag set by other cause");
  AST_STOP_WAKE: assert property (@(posedge sys_clk) disable iff (srst)
    state == ST_STOP && wake_s && !hard_rst && !ext_rst_act |=> state == ST_QCHECK
    && goal == GO_IRQ)
    else $error("stop wake without check");
  AST_WAIT_FETCH: assert property (@(posedge sys_clk)
    disable iff (srst || hard_rst || ext_rst_act)
    $past(state) == ST_WAIT && state == ST_RECOVER |-> ##[1:13] vector_fetch)
    else $error("wait recovery too slow");
  AST_STRAP: assert property (@(posedge sys_clk) disable iff (srst)
    state != ST_RESET |=> $stable(strap_q))
    else $error("strap moved outside reset");
  AST_MON: assert property (@(posedge sys_clk) disable iff (srst)
    mon_fail && osc_selected && !hard_rst |=> self_clock && sticky[F_MON])
    else $error("monitor failure ignored");
  AST_SELF_READ: assert property (@(posedge sys_clk) disable iff (srst)
    bus_req.rd && bus_req.addr == A_FLAGS |=> bus_rdata[F_SELF] == $past(self_clock))
    else $error("self clock status wrong");
endmodule : srcs_top

//--- rtl/srcs_pkg.sv
package srcs_pkg;
  // system clock rate
  localparam int CLK_MHZ = 25;

  // register bus shape
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // register byte offsets
  localparam logic [ADDR_W-1:0] A_FLAGS = 8'h00;
  localparam logic [ADDR_W-1:0] A_FLAG_CLR = 8'h04;
  localparam logic [ADDR_W-1:0] A_MODE = 8'h08;
  localparam logic [ADDR_W-1:0] A_INT_STAT = 8'h0C;
  localparam logic [ADDR_W-1:0] A_INT_CLR = 8'h10;
  localparam logic [ADDR_W-1:0] A_INT_EN = 8'h14;

  // flag register layout, low four bits are sticky
  localparam int STICKY_W = 4;
  localparam int FLAG_W = 7;
  localparam int F_PWR_ON = 0;
  localparam int F_LOWV = 1;
  localparam int F_EXT = 2;
  localparam int F_MON = 3;
  localparam int F_SELF = 4;
  localparam int F_OSC = 5;
  localparam int F_STRAP = 6;

  // interrupt status layout
  localparam int INT_W = 4;
  localparam int I_QC_DONE = 0;
  localparam int I_FALLBACK = 1;
  localparam int I_MON = 2;
  localparam int I_WAKE = 3;

  // low-power mode codes in the mode register
  localparam int MODE_W = 2;
  localparam logic [MODE_W-1:0] MODE_WAIT = 2'h1;
  localparam logic [MODE_W-1:0] MODE_PSTOP = 2'h2;
  localparam logic [MODE_W-1:0] MODE_STOP = 2'h3;

  // synchronised pin vector: index and reset level
  localparam int PIN_W = 6;
  localparam int P_PWR_ON = 0;
  localparam int P_LOWV = 1;
  localparam int P_EXT_N = 2;
  localparam int P_OSC = 3;
  localparam int P_STRAP = 4;
  localparam int P_WAKE_N = 5;
  localparam logic [PIN_W-1:0] PIN_RST = 6'h34;

  // timing in oscillator periods
  localparam int RST_MIN_OSC = 2;
  localparam int STARTUP_OSC = 192;
  localparam int STARTUP_MAX_OSC = 196;

  // wait recovery, bus cycles
  localparam int WRS_MAX_CYC = 14;

  // quality check timeout, least figure, in microseconds
  localparam int CQ_TIMEOUT_US = 450000;
  localparam int CQ_TIMEOUT_CYC = CQ_TIMEOUT_US * CLK_MHZ;

  // monitor fail frequency, lowest figure
  localparam int CMFA_KHZ = 50;
  localparam int CM_CYC = (CLK_MHZ * 1000) / CMFA_KHZ;

  // defaults with no documented figure
  localparam int QC_EDGES_DEF = 256;
  localparam int VUP_CYC_DEF = 16;
  localparam int REC_W = 8;
  localparam int SU_W = 8;

  // register bus request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } srcs_bus_req_t;
endpackage : srcs_pkg

//--- rtl/srcs_sync.sv
module srcs_sync
  import srcs_pkg::*;
#(
  parameter logic RST_VAL = 1'b0
)(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic async_in,
  output logic stable
);
  logic s1;
  logic s2;
  logic s3;

  // three stages, level moves once the last two agree
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      s1 <= RST_VAL;
      s2 <= RST_VAL;
      s3 <= RST_VAL;
      stable <= RST_VAL;
    end
    else
    begin
      s1 <= async_in;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3)
      begin
        stable <= s3;
      end
    end
  end
endmodule : srcs_sync

//--- rtl/srcs_osc_mon.sv
module srcs_osc_mon
  import srcs_pkg::*;
#(
  parameter int QC_EDGES = QC_EDGES_DEF,
  parameter int TIMEOUT_CYC = CQ_TIMEOUT_CYC,
  parameter int GAP_CYC = CM_CYC
)(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic start,
  input wire logic active,
  input wire logic osc_edge,
  output logic qc_pass,
  output logic qc_timeout,
  output logic mon_fail
);
  localparam int EW = $clog2(QC_EDGES + 1);
  localparam int TW = $clog2(TIMEOUT_CYC + 1);
  localparam int GW = $clog2(GAP_CYC + 1);
  localparam logic [EW-1:0] E_LAST = EW'(QC_EDGES - 1);
  localparam logic [TW-1:0] T_LAST = TW'(TIMEOUT_CYC - 1);
  localparam logic [GW-1:0] G_LAST = GW'(GAP_CYC - 1);

  logic busy;
  logic [EW-1:0] edge_cnt;
  logic [TW-1:0] to_cnt;
  logic [GW-1:0] gap_cnt;

  // quality check: enough edges before the timeout
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      busy <= 1'b0;
      edge_cnt <= '0;
      to_cnt <= '0;
      qc_pass <= 1'b0;
      qc_timeout <= 1'b0;
    end
    else
    begin
      qc_pass <= 1'b0;
      qc_timeout <= 1'b0;
      if (start)
      begin
        busy <= 1'b1;
        edge_cnt <= '0;
        to_cnt <= '0;
      end
      else if (busy)
      begin
        if (osc_edge && edge_cnt == E_LAST)
        begin
          qc_pass <= 1'b1;
          busy <= 1'b0;
        end
        else if (to_cnt == T_LAST)
        begin
          qc_timeout <= 1'b1;
          busy <= 1'b0;
        end
        else
        begin
          to_cnt <= to_cnt + 1'b1;
          if (osc_edge)
          begin
            edge_cnt <= edge_cnt + 1'b1;
          end
        end
      end
    end
  end

  // clock monitor: too long a gap between edges means failure
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      gap_cnt <= '0;
      mon_fail <= 1'b0;
    end
    else
    begin
      mon_fail <= 1'b0;
      if (!active || osc_edge)
      begin
        gap_cnt <= '0;
      end
      else if (gap_cnt == G_LAST)
      begin
        mon_fail <= 1'b1;
        gap_cnt <= '0;
      end
      else
      begin
        gap_cnt <= gap_cnt + 1'b1;
      end
    end
  end
endmodule : srcs_osc_mon

//--- dv/srcs_osc_model.sv
module srcs_osc_model
  import srcs_pkg::*;
#(
  parameter int HALF = 4
)(
  input wire logic sys_clk,
  input wire logic run,
  input wire logic osc_enable,
  output logic osc_clk
);
  timeunit 1ns;
  timeprecision 1ns;
  logic osc_q = 1'h0;
  int cnt = 0;
  assign osc_clk = osc_q;
  // crystal swings only while powered, else stands low
  always_ff @(posedge sys_clk)
  begin
    if (!(run && osc_enable))
    begin
      cnt <= 0;
      osc_q <= 1'h0;
    end
    else if (cnt == HALF - 1)
    begin
      cnt <= 0;
      osc_q <= ~osc_q;
    end
    else
      cnt <= cnt + 1;
  end
endmodule : srcs_osc_model

//--- dv/tb.sv
module tb
  import srcs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int QCE = 8;
  localparam int TMO = 2000;
  localparam int VUP = 4;
  localparam int OP = 8;
  typedef struct {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] e;} srcs_row_t;
  logic sys_clk = 1'h0, srst = 1'h1, pwr_on_req = 1'h0, lowv_req = 1'h0;
  logic ext_reset_n = 1'h1, strap = 1'h1, wake_irq_n = 1'h1, core_irq = 1'h0;
  logic osc_run = 1'h1, osc_clk, internal_reset, osc_enable, osc_selected;
  logic self_clock, colpitts_sel, clocks_released, vector_fetch, vector_is_irq, irq;
  logic [DATA_W-1:0] bus_rdata, rv;
  srcs_bus_req_t bus_req = '0;
  int err_total = 0, total_checks = 0, cyc_n = 0, n;
  // register map rows: write flag, offset, data, expected read
  srcs_row_t rows[11] = '{'{1'h0, A_FLAGS, 32'h0, 32'h60}, '{1'h0, A_INT_STAT, 32'h0, 32'h1},
    '{1'h1, A_INT_EN, 32'hF, 32'h0}, '{1'h0, A_INT_EN, 32'h0, 32'hF},
    '{1'h0, A_FLAG_CLR, 32'h0, 32'h0}, '{1'h0, A_MODE, 32'h0, 32'h0},
    '{1'h0, A_INT_CLR, 32'h0, 32'h0}, '{1'h0, 8'h18, 32'h0, 32'h0},
    '{1'h1, A_INT_CLR, 32'h1, 32'h0}, '{1'h1, A_FLAGS, 32'hFF, 32'h0},
    '{1'h0, A_INT_STAT, 32'h0, 32'h0}};

  always #20 sys_clk = ~sys_clk;

  srcs_osc_model #(.HALF(OP / 2)) xtal (.sys_clk(sys_clk), .run(osc_run),
    .osc_enable(osc_enable), .osc_clk(osc_clk));
  srcs_top #(.QC_EDGES(QCE), .CQ_TIMEOUT_CYCLES(TMO), .VUP_CYCLES(VUP)) uut (
    .sys_clk(sys_clk), .srst(srst), .pwr_on_req(pwr_on_req), .lowv_req(lowv_req),
    .ext_reset_n(ext_reset_n), .osc_clk_in(osc_clk), .osc_select_strap(strap),
    .wake_irq_n(wake_irq_n), .core_irq(core_irq), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .internal_reset(internal_reset), .osc_enable(osc_enable), .osc_selected(osc_selected),
    .self_clock(self_clock), .colpitts_sel(colpitts_sel), .clocks_released(clocks_released),
    .vector_fetch(vector_fetch), .vector_is_irq(vector_is_irq), .irq(irq));

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH t=%0t got %0h want %0h", $time, got, exp);
    end
  endtask : chk

  task automatic chk1(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask : chk1

  task automatic rng(input int lo, input int hi);
    chk1(n >= lo && n <= hi, 1'h1);
  endtask : rng

  // one strobe cycle, read data sampled in the cycle after
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    bus_req <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge sys_clk);
    bus_req <= '0;
    #1 rv = bus_rdata;
  endtask : bus

  function automatic logic pick(input int s);
    return s == 0 ? vector_fetch : s == 1 ? osc_selected : self_clock;
  endfunction : pick

  // bounded wait, n counts cycles
  task automatic till(input int s, input int mx);
    n = 0;
    while (pick(s) !== 1'h1 && n < mx)
    begin
      @(posedge sys_clk);
      #1 n++;
    end
  endtask : till

  // hang guard
  always @(posedge sys_clk)
  begin
    cyc_n++;
    if (cyc_n == 30000)
    begin
      err_total++;
      tally_and_finish();
    end
  end

  initial
  begin
    repeat (5) @(posedge sys_clk);
    #1 chk1(internal_reset, 1'h1);
    chk1(colpitts_sel, 1'h1);
    @(posedge sys_clk);
    srst <= 1'h0;
    till(1, 3000);
    chk1(internal_reset, 1'h1);
    till(0, 3000);
    rng(190 * OP, 197 * OP);
    chk1(vector_is_irq, 1'h0);
    foreach (rows[i])
    begin
      bus(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w)
        chk(rv, rows[i].e);
    end
    // warm external reset skips the check
    @(posedge sys_clk);
    ext_reset_n <= 1'h0;
    repeat (5 * OP) @(posedge sys_clk);
    #1 chk1(internal_reset, 1'h1);
    @(posedge sys_clk);
    ext_reset_n <= 1'h1;
    till(0, 3000);
    rng(190 * OP, 197 * OP);
    chk1(osc_selected, 1'h1);
    bus(1'h0, A_FLAGS, '0);
    chk(rv & 32'h5, 32'h4);
    bus(1'h0, A_INT_STAT, '0);
    chk(rv & 32'h1, 32'h0);
    // wait and pseudo-stop recovery
    bus(1'h1, A_MODE, 32'h1);
    repeat (2) @(posedge sys_clk);
    core_irq <= 1'h1;
    till(0, 40);
    rng(12, WRS_MAX_CYC);
    chk1(vector_is_irq, 1'h1);
    @(posedge sys_clk);
    core_irq <= 1'h0;
    bus(1'h1, A_MODE, 32'h2);
    #1 chk1(irq, 1'h1);
    repeat (2) @(posedge sys_clk);
    wake_irq_n <= 1'h0;
    till(0, 60);
    rng(VUP + 12, VUP + WRS_MAX_CYC + 5);
    @(posedge sys_clk);
    wake_irq_n <= 1'h1;
    // stop: oscillator off, core interrupt refused, wake rechecks
    repeat (5) @(posedge sys_clk);
    bus(1'h1, A_MODE, 32'h3);
    repeat (3) @(posedge sys_clk);
    core_irq <= 1'h1;
    #1 chk1(osc_enable, 1'h0);
    till(0, 30);
    rng(30, 30);
    @(posedge sys_clk);
    core_irq <= 1'h0;
    wake_irq_n <= 1'h0;
    repeat (6) @(posedge sys_clk);
    #1 chk1(clocks_released, 1'h0);
    till(0, TMO + 200);
    rng(6 * OP, 4 * QCE * OP);
    chk1(osc_selected, 1'h1);
    chk1(vector_is_irq, 1'h1);
    @(posedge sys_clk);
    wake_irq_n <= 1'h1;
    osc_run <= 1'h0;
    // oscillator dies: monitor, then recheck times out
    till(2, 700);
    rng(CM_CYC - OP, CM_CYC + 2 * OP);
    chk1(clocks_released, 1'h1);
    repeat (TMO + 100) @(posedge sys_clk);
    bus(1'h0, A_FLAGS, '0);
    chk(rv & 32'h38, 32'h18);
    bus(1'h0, A_INT_STAT, '0);
    chk(rv & 32'h6, 32'h6);
    chk1(irq, 1'h1);
    bus(1'h1, A_INT_CLR, 32'hF);
    bus(1'h0, A_INT_STAT, '0);
    chk(rv, 32'h0);
    chk1(irq, 1'h0);
    // power-on with the other strap level
    @(posedge sys_clk);
    strap <= 1'h0;
    osc_run <= 1'h1;
    pwr_on_req <= 1'h1;
    repeat (10) @(posedge sys_clk);
    #1 chk1(osc_enable, 1'h0);
    @(posedge sys_clk);
    pwr_on_req <= 1'h0;
    till(1, 3000);
    chk1(osc_selected, 1'h1);
    chk1(internal_reset, 1'h1);
    till(0, 3000);
    rng(190 * OP, 197 * OP);
    chk1(colpitts_sel, 1'h0);
    bus(1'h0, A_FLAGS, '0);
    chk(rv & 32'h71, 32'h21);
    bus(1'h1, A_FLAG_CLR, 32'h1);
    bus(1'h0, A_FLAGS, '0);
    chk(rv & 32'h1, 32'h0);
    // low-voltage with a dead crystal falls back
    @(posedge sys_clk);
    osc_run <= 1'h0;
    lowv_req <= 1'h1;
    repeat (10) @(posedge sys_clk);
    lowv_req <= 1'h0;
    till(2, TMO + 100);
    rng(TMO, TMO + 40);
    chk1(osc_selected, 1'h0);
    bus(1'h0, A_FLAGS, '0);
    chk(rv & 32'h13, 32'h12);
    tally_and_finish();
  end
endmodule : tb
